// ### hw/oag_pkg.sv
// Shared types and constants of the operand and program address generator
package oag_pkg;

	// ==========================================================
	// Data space layout
	localparam logic [15:0] REG_BASE = 16'h0000;
	localparam logic [15:0] IO_BASE = 16'h0020;
	localparam logic [15:0] SRAM_BASE = 16'h0060;
	localparam logic [15:0] DATA_END = 16'h00e0;
	localparam int NUM_WORK_REGS = 32;
	localparam int IO_ADDR_W = 6;
	localparam int SRAM_ADDR_W = 7;

	// ==========================================================
	// Pointer pairs: index of the low byte, high byte is the next one
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [4:0] PTR_Y_LO = 5'h1c;
	localparam logic [4:0] PTR_Z_LO = 5'h1e;

	// ==========================================================
	// Program side and timing
	localparam int PC_W = 10;
	localparam logic [9:0] PC_RESET = 10'h000;
	localparam logic [9:0] PC_STEP_ONE = 10'h001;
	localparam logic [9:0] PC_STEP_TWO = 10'h002;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SRAM_ACCESS_CYCLES = 2;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ==========================================================
	// Enumerations
	typedef enum logic [3:0] {
		M_NONE, M_SINGLE, M_PAIR, M_IO_DIRECT, M_DATA_DIRECT, M_IND_DISP, M_IND,
		M_IND_PREDEC, M_IND_POSTINC, M_PROG_CONST, M_POINTER_JUMP, M_RELATIVE_JUMP
	} mode_e;

	typedef enum logic [2:0] {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV} alu_op_e;

	typedef enum logic [1:0] {SEL_X, SEL_Y, SEL_Z} ptr_sel_e;

	typedef enum logic [1:0] {SRC_NONE, SRC_IO, SRC_SRAM, SRC_PROG} load_src_e;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic valid;
		mode_e mode;
		alu_op_e op;
		logic store;
		logic [4:0] rd;
		logic [4:0] source_operand_register;
		ptr_sel_e sel;
		logic [5:0] io_addr;
		logic [5:0] disp;
		logic [15:0] data_addr;
		logic [11:0] rel_k;
	} req_s;

	typedef struct packed {
		logic en;
		logic we;
		logic [5:0] addr;
		logic [7:0] wdata;
	} io_bus_s;

	typedef struct packed {
		logic en;
		logic we;
		logic [6:0] addr;
		logic [7:0] wdata;
	} sram_bus_s;

	typedef struct packed {
		logic en;
		logic [9:0] word_addr;
	} prog_bus_s;

endpackage

// ### hw/operand_address_generator.sv
// Operand and program address generator with working register file and program counter
`timescale 1ns/1ps
// ==========================================================
// What this block does
// - Single register operand comes from destination
// - Two register op writes result to destination
// - I/O location from six-bit instruction field
// - Data direct uses sixteen-bit instruction address
// - X, Y or Z plus six-bit displacement
// - Plain indirect uses unmodified pointer value
// - Pre-decrement pointer, use and keep result
// - Post-increment: use original, store incremented
// - Constant load: Z word address, bit0 byte
// - Pointer jump loads Z
// - Relative jump goes to PC plus k plus one
// - Register ALU operation completes in one cycle
// - SRAM access takes two clock cycles
// - Ten-bit program counter, 1024 words
// - Decode 224 locations: registers, I/O, SRAM
// - Direct addressing reaches whole data space
// - R26 to R31 serve as pointers
// - Every data mode but I/O direct reaches registers, I/O, SRAM; I/O direct reaches I/O only
// - Core runs straight from system clock
// - X, Y, Z built from register pairs
module operand_address_generator (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire oag_pkg::req_s i_req,
	input wire logic [7:0] i_io_rdata,
	input wire logic [7:0] i_sram_rdata,
	input wire logic [15:0] i_prog_word,
	output logic o_busy,
	output logic o_done,
	output logic o_addr_err,
	output logic [7:0] o_operand,
	output logic [9:0] o_pc,
	output oag_pkg::io_bus_s o_io,
	output oag_pkg::sram_bus_s o_sram,
	output oag_pkg::prog_bus_s o_prog
);
	import oag_pkg::*;

	typedef enum logic {ST_IDLE, ST_WAIT} state_e;

	// ==========================================================
	// Helpers
	function automatic logic [4:0] pair_low(input ptr_sel_e sel);
		case (sel)
			SEL_X: pair_low = PTR_X_LO;
			SEL_Y: pair_low = PTR_Y_LO;
			default: pair_low = PTR_Z_LO;
		endcase
	endfunction

	function automatic logic [7:0] alu(input alu_op_e op, input logic [7:0] a, input logic [7:0] b);
		case (op)
			OP_ADD: alu = a + b;
			OP_SUB: alu = a - b;
			OP_AND: alu = a & b;
			OP_OR: alu = a | b;
			OP_XOR: alu = a ^ b;
			default: alu = b;
		endcase
	endfunction

	// ==========================================================
	// State
	logic [7:0] regs [0:NUM_WORK_REGS-1];
	state_e state;
	load_src_e pend_src;
	logic pend_load;
	logic pend_hi;
	logic [4:0] pend_rd;

	// ==========================================================
	// Request decode and pointer selection
	wire take = i_req.valid && (state == ST_IDLE);
	wire [4:0] ptr_lo = pair_low(i_req.sel);
	wire [4:0] ptr_hi = ptr_lo | 5'h01;
	wire [15:0] cur_ptr = {regs[ptr_hi], regs[ptr_lo]};
	wire [15:0] z_ptr = {regs[PTR_Z_LO | 5'h01], regs[PTR_Z_LO]};
	wire [15:0] ptr_inc = cur_ptr + 16'h0001;
	wire [15:0] ptr_dec = cur_ptr - 16'h0001;
	wire [7:0] rd_val = regs[i_req.rd];
	wire [7:0] rr_val = regs[i_req.source_operand_register];
	wire [7:0] alu_res = alu(i_req.op, rd_val, rr_val);

	// Effective data address of every data mode
	wire is_io = (i_req.mode == M_IO_DIRECT);
	wire is_direct = (i_req.mode == M_DATA_DIRECT);
	wire is_disp = (i_req.mode == M_IND_DISP);
	wire is_ind = (i_req.mode == M_IND);
	wire is_predec = (i_req.mode == M_IND_PREDEC);
	wire is_postinc = (i_req.mode == M_IND_POSTINC);
	wire is_data = is_io | is_direct | is_disp | is_ind | is_predec | is_postinc;
	wire [15:0] ea = is_io ? IO_BASE + {10'h000, i_req.io_addr} :
		is_direct ? i_req.data_addr :
		is_disp ? cur_ptr + {10'h000, i_req.disp} :
		is_predec ? ptr_dec :
		cur_ptr;

	// Region decode of the 224-location data space
	wire in_reg = (ea < IO_BASE);
	wire in_io = (ea >= IO_BASE) && (ea < SRAM_BASE);
	wire in_sram = (ea >= SRAM_BASE) && (ea < DATA_END);
	wire [15:0] io_off = ea - IO_BASE;
	wire [15:0] sram_off = ea - SRAM_BASE;
	wire [7:0] reg_rdata = regs[ea[4:0]];

	// Relative target wraps inside the ten-bit program space
	wire [15:0] rel_ext = {{4{i_req.rel_k[11]}}, i_req.rel_k};
	wire [15:0] rel_sum = {6'h00, o_pc} + rel_ext + 16'h0001;

	// Byte coming back from an outside access
	wire [7:0] prog_byte = pend_hi ? i_prog_word[15:8] : i_prog_word[7:0];
	wire [7:0] load_byte = (pend_src == SRC_IO) ? i_io_rdata :
		(pend_src == SRC_SRAM) ? i_sram_rdata : prog_byte;
	wire finish_load = (state == ST_WAIT) && pend_load;

	// ==========================================================
	// Working register file. Pointer update and data access share one edge;
	// the data access is written last so a store onto a pointer byte wins.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < NUM_WORK_REGS; i++) begin
				regs[i] <= REG_RESET;
			end
		end else begin
			if (take && i_req.mode == M_PAIR) begin
				regs[i_req.rd] <= alu_res;
			end
			if (take && is_predec) begin
				regs[ptr_lo] <= ptr_dec[7:0];
				regs[ptr_hi] <= ptr_dec[15:8];
			end
			if (take && is_postinc) begin
				regs[ptr_lo] <= ptr_inc[7:0];
				regs[ptr_hi] <= ptr_inc[15:8];
			end
			if (take && is_data && in_reg) begin
				if (i_req.store) begin
					regs[ea[4:0]] <= rr_val;
				end else begin
					regs[i_req.rd] <= reg_rdata;
				end
			end
			if (finish_load) begin
				regs[pend_rd] <= load_byte;
			end
		end
	end

	// ==========================================================
	// Sequencer: one clock straight from the system clock, no dividers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			pend_src <= SRC_NONE;
			pend_load <= 1'b0;
			pend_hi <= 1'b0;
			pend_rd <= 5'h00;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_addr_err <= 1'b0;
			o_operand <= 8'h00;
			o_pc <= PC_RESET;
			o_io <= '0;
			o_sram <= '0;
			o_prog <= '0;
		end else begin
			o_done <= 1'b0;
			o_addr_err <= 1'b0;
			o_io.en <= 1'b0;
			o_sram.en <= 1'b0;
			o_prog.en <= 1'b0;
			if (state == ST_WAIT) begin
				// Second cycle of an outside access
				state <= ST_IDLE;
				o_busy <= 1'b0;
				o_done <= 1'b1;
				if (pend_load) begin
					o_operand <= load_byte;
				end
			end else if (take) begin
				pend_rd <= i_req.rd;
				pend_load <= 1'b0;
				pend_src <= SRC_NONE;
				o_done <= 1'b1;
				o_pc <= o_pc + PC_STEP_ONE;
				case (i_req.mode)
					M_SINGLE: o_operand <= rd_val;
					M_PAIR: o_operand <= alu_res;
					M_DATA_DIRECT, M_IO_DIRECT, M_IND_DISP, M_IND, M_IND_PREDEC, M_IND_POSTINC: begin
						if (is_direct) begin
							o_pc <= o_pc + PC_STEP_TWO;
						end
						if (in_reg) begin
							o_operand <= i_req.store ? rr_val : reg_rdata;
						end else if (in_io) begin
							// I/O and SRAM answer on the edge after the strobe
							o_io.en <= 1'b1;
							o_io.we <= i_req.store;
							o_io.addr <= io_off[5:0];
							o_io.wdata <= rr_val;
							o_operand <= rr_val;
							pend_src <= SRC_IO;
							pend_load <= !i_req.store;
							state <= ST_WAIT;
							o_busy <= 1'b1;
							o_done <= 1'b0;
						end else if (in_sram) begin
							o_sram.en <= 1'b1;
							o_sram.we <= i_req.store;
							o_sram.addr <= sram_off[6:0];
							o_sram.wdata <= rr_val;
							o_operand <= rr_val;
							pend_src <= SRC_SRAM;
							pend_load <= !i_req.store;
							state <= ST_WAIT;
							o_busy <= 1'b1;
							o_done <= 1'b0;
						end else begin
							// Beyond the data space: no bus or data byte is touched, only the pointer step applies, error flagged
							o_addr_err <= 1'b1;
						end
					end
					M_PROG_CONST: begin
						o_prog.en <= 1'b1;
						o_prog.word_addr <= z_ptr[10:1];
						pend_hi <= z_ptr[0];
						pend_src <= SRC_PROG;
						pend_load <= 1'b1;
						state <= ST_WAIT;
						o_busy <= 1'b1;
						o_done <= 1'b0;
					end
					M_POINTER_JUMP: o_pc <= z_ptr[9:0];
					M_RELATIVE_JUMP: o_pc <= rel_sum[9:0];
					default: o_pc <= o_pc + PC_STEP_ONE;
				endcase
			end
		end
	end

	// ==========================================================
	// Helper state for the checks below
	logic [4:0] h_rd;
	ptr_sel_e h_sel;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			h_rd <= 5'h00;
			h_sel <= SEL_X;
		end else if (take) begin
			h_rd <= i_req.rd;
			h_sel <= i_req.sel;
		end
	end
	wire [4:0] h_lo = pair_low(h_sel);
	wire [15:0] h_ptr = {regs[h_lo | 5'h01], regs[h_lo]};
	wire [7:0] h_rd_val = regs[h_rd];

	// ==========================================================
	// Checks
	AST_SINGLE_OPERAND: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && i_req.mode == M_SINGLE |=> o_done && o_operand == $past(rd_val))
		else $error("single register operand wrong");

	AST_ALU_ONE_CYCLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && i_req.mode == M_PAIR |=> h_rd_val == $past(alu_res) && o_done)
		else $error("register result not written within one cycle");

	AST_IO_DIRECT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_io |=> o_io.en && o_io.addr == $past(i_req.io_addr) ##1 o_done)
		else $error("io direct address wrong");

	AST_DIRECT_SRAM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_direct && in_sram |=> o_sram.en && o_sram.addr == 7'($past(i_req.data_addr) - 16'h0060))
		else $error("data direct sram address wrong");

	AST_PREDEC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_predec && !in_reg |=> h_ptr == $past(cur_ptr) - 16'h0001)
		else $error("pointer not kept decremented");

	AST_POSTINC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_postinc && !in_reg |=> h_ptr == $past(cur_ptr) + 16'h0001)
		else $error("pointer not incremented after use");

	AST_SRAM_TWO_CYCLES: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_data && in_sram |=> (o_sram.en && o_busy && !o_done) ##1 (o_done && !o_sram.en && !o_busy))
		else $error("sram access not two cycles");

	AST_POINTER_JUMP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && i_req.mode == M_POINTER_JUMP |=> o_pc == $past(z_ptr[9:0]))
		else $error("pointer jump target wrong");

	AST_RELATIVE_JUMP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && i_req.mode == M_RELATIVE_JUMP |=> o_pc == $past(o_pc) + $past(i_req.rel_k[9:0]) + 10'h001)
		else $error("relative jump target wrong");

	AST_CONST_FETCH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && i_req.mode == M_PROG_CONST |=> o_prog.en && o_prog.word_addr == $past(z_ptr[10:1]) ##1 o_done)
		else $error("constant fetch address wrong");

	// ==========================================================
	// Address forming of the pointer modes, seen on the SRAM strobe.
	// Checked in SRAM only: there the address leaves the block and a slip would go unseen.
	AST_PLAIN_INDIRECT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_ind && in_sram |=> o_sram.en && o_sram.addr == 7'($past(cur_ptr) - 16'h0060))
		else $error("plain indirect address wrong");

	AST_DISPLACEMENT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_disp && in_sram |=>
		o_sram.addr == 7'($past(cur_ptr) + 16'($past(i_req.disp)) - 16'h0060))
		else $error("displacement address wrong");

	AST_PREDEC_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_predec && in_sram |=> o_sram.addr == 7'($past(cur_ptr) - 16'h0061))
		else $error("pre-decrement does not use the decremented pointer");

	AST_POSTINC_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_postinc && in_sram |=> o_sram.addr == 7'($past(cur_ptr) - 16'h0060))
		else $error("post-increment does not use the original pointer");

	// Region decode: the register region stays local, the top of the map is refused
	AST_REG_REGION_LOCAL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_data && in_reg |=> o_done && !o_busy && !o_io.en && !o_sram.en)
		else $error("register region access left the block");

	AST_UNMAPPED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_data && !in_reg && !in_io && !in_sram |=> o_addr_err && o_done && !o_io.en && !o_sram.en)
		else $error("unmapped access not refused");

	// Program counter steps and the byte pick of a constant load
	AST_PC_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && (i_req.mode == M_SINGLE || i_req.mode == M_PAIR) |=> o_pc == $past(o_pc) + 10'h001)
		else $error("program counter step wrong");

	AST_DIRECT_PC_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && is_direct |=> o_pc == $past(o_pc) + 10'h002)
		else $error("two-word instruction did not skip its address word");

	AST_CONST_BYTE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && i_req.mode == M_PROG_CONST |=> ##1
		o_operand == ($past(z_ptr[0], 2) ? $past(i_prog_word[15:8]) : $past(i_prog_word[7:0])))
		else $error("constant byte pick wrong");

	// The wait state never stretches: busy lasts exactly one cycle
	AST_BUSY_ONE_CYCLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_busy |=> !o_busy && o_done)
		else $error("outside access longer than two cycles");

endmodule

// ### tb/memory_side_model.sv
// Behavioural model of the I/O space, data SRAM and program memory
`timescale 1ns/1ps
// ==========================================================
// Far side of the generator
module memory_side_model (
	input wire logic i_clk,
	input wire oag_pkg::io_bus_s i_io,
	input wire oag_pkg::sram_bus_s i_sram,
	input wire oag_pkg::prog_bus_s i_prog,
	output logic [7:0] o_io_rdata,
	output logic [7:0] o_sram_rdata,
	output logic [15:0] o_prog_word
);
	import oag_pkg::*;
	logic [7:0] io_m [64];
	logic [7:0] sram_m [128];
	logic [7:0] cyc = 8'h00;
	// SRAM holds its own offset, so a load can fetch any byte below 0x80
	initial for (int i = 0; i < 128; i++) begin
		sram_m[i] = 8'(i);
		if (i < 64) io_m[i] = 8'(i) ^ 8'ha5;
	end
	// Writes land on the edge that closes the strobe cycle
	always @(posedge i_clk) begin
		cyc <= cyc + 8'h01;
		if (i_io.en && i_io.we) io_m[i_io.addr] <= i_io.wdata;
		if (i_sram.en && i_sram.we) sram_m[i_sram.addr] <= i_sram.wdata;
	end
	// Unstrobed buses show a moving pattern, never the last data
	assign o_io_rdata = i_io.en ? io_m[i_io.addr] : ~cyc;
	assign o_sram_rdata = i_sram.en ? sram_m[i_sram.addr] : cyc;
	assign o_prog_word = i_prog.en ? {i_prog.word_addr[7:0] ^ 8'h3c, i_prog.word_addr[7:0] + 8'h11} : {cyc, ~cyc};
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the operand and program address generator
`timescale 1ns/1ps
module tb_top;
	import oag_pkg::*;
	typedef struct packed {logic op_ok; logic [7:0] op; logic [9:0] pc; logic err;} note_s;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	req_s i_req = '0;
	logic [7:0] io_rdata, sram_rdata, o_operand;
	logic [15:0] prog_word;
	logic o_busy, o_done, o_addr_err;
	logic [9:0] o_pc;
	io_bus_s o_io;
	sram_bus_s o_sram;
	prog_bus_s o_prog;
	int n_errors = 0;
	int samples_checked = 0;
	logic [31:0] lf = 32'hf76d;
	logic [7:0] rg [32];
	logic [7:0] sr [128];
	logic [7:0] iom [64];
	logic [9:0] pc_m = 10'h000;
	note_s q [$];

	// ==========================================================
	// Clock, design and far side
	always #2 i_clk = ~i_clk;
	operand_address_generator i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_io_rdata(io_rdata),
		.i_sram_rdata(sram_rdata), .i_prog_word(prog_word), .o_busy(o_busy), .o_done(o_done),
		.o_addr_err(o_addr_err), .o_operand(o_operand), .o_pc(o_pc), .o_io(o_io), .o_sram(o_sram), .o_prog(o_prog));
	memory_side_model i_mem (.i_clk(i_clk), .i_io(o_io), .i_sram(o_sram), .i_prog(o_prog),
		.o_io_rdata(io_rdata), .o_sram_rdata(sram_rdata), .o_prog_word(prog_word));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction
	function automatic logic [7:0] alu(alu_op_e o, logic [7:0] a, logic [7:0] b);
		case (o)
			OP_ADD: return a + b;
			OP_SUB: return a - b;
			OP_AND: return a & b;
			OP_OR: return a | b;
			OP_XOR: return a ^ b;
			default: return b;
		endcase
	endfunction
	// Request of mode m whose other fields come from one random word, with sel forced to Z from M_PROG_CONST up
	function automatic req_s mk(mode_e m, logic [31:0] x);
		req_s r;
		r = req_s'(61'({x, x}));
		r.mode = m;
		r.op = alu_op_e'(3'(x % 32'h6));
		r.sel = (m >= M_PROG_CONST) ? SEL_Z : ptr_sel_e'(2'(x % 32'h3));
		r.rd = x[4:0];
		r.data_addr = {8'h00, x[19:12]};
		return r;
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (e !== g) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Work out the expected result, note it, then run the request
	task automatic go(input req_s r);
		logic [15:0] p, ea, lat;
		logic [4:0] lo;
		logic acc;
		note_s e;
		int n;
		r.valid = 1'b1;
		lo = (r.sel == SEL_X) ? 5'h1a : (r.sel == SEL_Y) ? 5'h1c : 5'h1e;
		p = {rg[lo + 5'h01], rg[lo]};
		e = '{1'b1, 8'h00, pc_m + 10'h001, 1'b0};
		ea = p;
		acc = r.mode inside {M_IO_DIRECT, M_DATA_DIRECT, M_IND_DISP, M_IND, M_IND_PREDEC, M_IND_POSTINC};
		case (r.mode)
			M_SINGLE: e.op = rg[r.rd];
			M_PAIR: begin
				e.op = alu(r.op, rg[r.rd], rg[r.source_operand_register]);
				rg[r.rd] = e.op;
			end
			M_IO_DIRECT: ea = 16'h0020 + 16'(r.io_addr);
			M_DATA_DIRECT: begin
				ea = r.data_addr;
				e.pc = pc_m + 10'h002;
			end
			M_IND_DISP: ea = p + 16'(r.disp);
			M_IND: ea = p;
			M_IND_PREDEC: ea = p - 16'h0001;
			M_IND_POSTINC: ea = p;
			M_PROG_CONST: begin
				e.op = p[0] ? (8'(p[8:1]) ^ 8'h3c) : (8'(p[8:1]) + 8'h11);
				rg[r.rd] = e.op;
			end
			M_POINTER_JUMP: e.pc = p[9:0];
			default: e.pc = pc_m + 10'(r.rel_k) + 10'h001;
		endcase
		if (acc) begin
			e.err = ea >= 16'h00e0;
			e.op_ok = !e.err;
			e.op = r.store ? rg[r.source_operand_register] : (ea < 16'h0020) ? rg[ea[4:0]] :
				(ea < 16'h0060) ? iom[ea[5:0] - 6'h20] : sr[ea[6:0] - 7'h60];
			// Pointer steps after the read, so a load sees the old byte and a store still wins
			if (r.mode == M_IND_PREDEC) {rg[lo + 5'h01], rg[lo]} = ea;
			if (r.mode == M_IND_POSTINC) {rg[lo + 5'h01], rg[lo]} = p + 16'h0001;
			if (!e.err && r.store) begin
				if (ea < 16'h0020) rg[ea[4:0]] = e.op;
				else if (ea < 16'h0060) iom[ea[5:0] - 6'h20] = e.op;
				else sr[ea[6:0] - 7'h60] = e.op;
			end else if (!e.err) rg[r.rd] = e.op;
		end
		if (r.mode inside {M_POINTER_JUMP, M_RELATIVE_JUMP}) e.op_ok = 1'b0;
		lat = ((acc && !e.err && ea >= 16'h0020) || r.mode == M_PROG_CONST) ? 16'h2 : 16'h1;
		pc_m = e.pc;
		q.push_back(e);
		i_req <= r;
		@(posedge i_clk);
		// Valid stays up over the busy edge, where it must be ignored
		i_req.valid <= (lat == 16'h2);
		for (n = 1; n < 9; n++) begin
			#1;
			if (n == 1) chk("busy", lat - 16'h1, 16'(o_busy));
			if (o_done === 1'b1) break;
			@(posedge i_clk);
			i_req.valid <= 1'b0;
		end
		chk("latency", lat, 16'(n));
		if (n >= 9) tally_and_finish();
		@(posedge i_clk);
	endtask
	task automatic ld(input logic [4:0] d, input logic [15:0] a);
		req_s r;
		r = mk(M_DATA_DIRECT, 32'h0);
		r.rd = d;
		r.data_addr = a;
		go(r);
	endtask

	// ==========================================================
	// Each done pulse retires the oldest note
	always @(negedge i_clk) begin
		note_s e;
		if (o_done === 1'b1) begin
			if (q.size() == 0) chk("extra_done", 16'h0, 16'h1);
			else begin
				e = q.pop_front();
				chk("pc", 16'(e.pc), 16'(o_pc));
				chk("addr_err", 16'(e.err), 16'(o_addr_err));
				if (e.op_ok) chk("operand", 16'(e.op), 16'(o_operand));
			end
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		req_s r;
		logic [31:0] x;
		for (int i = 0; i < 128; i++) begin
			sr[i] = 8'(i);
			if (i < 64) iom[i] = 8'(i) ^ 8'ha5;
			if (i < 32) rg[i] = 8'h00;
		end
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		chk("reset_pc", 16'h0, 16'(o_pc));
		// Every register loaded by direct addressing, then read back
		for (int i = 0; i < 32; i++) ld(5'(i), 16'h0060 + 16'(rnd() & 32'h7f));
		for (int i = 0; i < 32; i++) go(mk(M_SINGLE, 32'(i)));
		for (int i = 0; i < 24; i++) go(mk(M_PAIR, rnd()));
		// Data modes over registers, I/O, SRAM and the unmapped top
		for (int i = 0; i < 90; i++) begin
			x = rnd();
			r = mk(mode_e'(4'(3 + i % 6)), x);
			r.rd[4] = 1'b0;
			r.source_operand_register[4] = 1'b0;
			ld(5'h1a + 5'(2 * r.sel), 16'h0060 + 16'(x[26:20]));
			ld(5'h1b + 5'(2 * r.sel), 16'h0060);
			go(r);
		end
		// Pointer steps wrap below zero and carry into the high byte
		ld(5'h1a, 16'h0060);
		ld(5'h1b, 16'h0060);
		go(mk(M_IND_PREDEC, 32'h0));
		go(mk(M_IND_POSTINC, 32'h0));
		ld(5'h1a, 16'h00df);
		r = mk(M_PAIR, 32'h0);
		r.rd = 5'h1a;
		r.source_operand_register = 5'h1a;
		go(r);
		repeat (2) go(mk(M_IND_POSTINC, 32'h0));
		go(mk(M_IND, 32'h0));
		// Constant fetch and program jumps
		for (int i = 0; i < 12; i++) begin
			x = rnd();
			ld(5'h1e, 16'h0060 + 16'(x[6:0]));
			ld(5'h1f, 16'h0060 + 16'(x[10:8]));
			go(mk(M_PROG_CONST, x));
			go(mk(M_POINTER_JUMP, x));
			go(mk(M_RELATIVE_JUMP, x));
		end
		r = mk(M_RELATIVE_JUMP, 32'h800);
		go(r);
		r.rel_k = 12'h7ff;
		go(r);
		tally_and_finish();
	end
endmodule
